/* common/adsw_regs.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * aperture delay and capture window block.
 * assumes a 32-bit apb slave, one register per aligned word.
 */
`ifndef ADSW_REGS_SVH
`define ADSW_REGS_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define ADSW_OFF_DELAY 12'h000
`define ADSW_OFF_RAMP 12'h004
`define ADSW_OFF_TAPCTL 12'h008
`define ADSW_OFF_POS 12'h00C
`define ADSW_OFF_STATUS 12'h010

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define ADSW_FINE_LSB 0
`define ADSW_COARSE_LSB 8
`define ADSW_INV_BIT 16
`define ADSW_RAMP_EN_BIT 0
`define ADSW_RAMP_RATE_BIT 1
`define ADSW_SEL_LSB 0
`define ADSW_ZOOM_BIT 4
`define ADSW_SEL_W 4
`define ADSW_TAPS 24

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define ADSW_DELAY_RST 8'h00
`define ADSW_ZOOM_RST 1'b1
`define ADSW_RAMP_PERIOD 256
`define ADSW_FAST_STEPS 4
`define ADSW_MIN_EDGES 3
`define ADSW_EDGE_MARGIN_TAPS 1

`endif

/* common/adsw_pkg.sv */
/*
 * types shared by the aperture delay and capture window block.
 * assumes adsw_regs.svh is included by the design file.
 */
`default_nettype none
package adsw_pkg;
    typedef logic [7:0] adsw_code_t;
    typedef enum logic [1:0] {
        ADSW_IDLE = 2'b01,
        ADSW_RAMP = 2'b10
    } adsw_ramp_state_t;
endpackage
`default_nettype wire

/* verilog/adsw_core.sv */
/*
 * aperture delay codes with a coarse ramp, and a capture window detector
 * with tap select for the reference pulse, behind an apb slave.
 * assumes pclk is the device clock; sysref_pin and tap_sample_pin come from
 * outside and are synchronised here; analog delay stages sit outside.
 */
// The implementer's own choices: the register addresses and the APB interface to the registers.
//
// Behaviour
// - invert bit adds half clock delay
// - coarse and fine codes, 256 steps
// - three delay controls act independently, summed
// - all internal clocks follow the delay
// - delay may change during operation
// - ramp walks coarse toward written target
// - slow 1, fast 4 steps per 256
// - coarse write restarts ramp from present
// - reference caught on deterministic clock edge
// - single channel samples on both edges
// - reference captured by selected delayed tap
// - flags valid after three reference edges
// - flag set means tap at risk
// - flag bits 0 and 23 always set
// - 24 flags, select reaches taps 0-15
// - zoom picks coarse or fine tap spacing
`include "adsw_regs.svh"
`default_nettype none
module adsw_core (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter side
    input wire logic single_channel_mode,
    input wire logic sysref_pin,
    input wire logic [`ADSW_TAPS-1:0] tap_sample_pin,
    output logic clock_invert_delay,
    output adsw_pkg::adsw_code_t coarse_delay_code,
    output adsw_pkg::adsw_code_t fine_delay_code,
    output logic [`ADSW_SEL_W-1:0] sample_tap_select,
    output logic tap_step_zoom,
    output logic dual_edge_sample,
    output logic sysref_captured
);
    import adsw_pkg::*;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire logic wr_en = psel & penable & pwrite;
    wire logic hit_delay = (paddr == `ADSW_OFF_DELAY);
    wire logic hit_ramp = (paddr == `ADSW_OFF_RAMP);
    wire logic hit_tapctl = (paddr == `ADSW_OFF_TAPCTL);
    wire logic hit_pos = (paddr == `ADSW_OFF_POS);
    wire logic hit_status = (paddr == `ADSW_OFF_STATUS);
    wire logic hit_any = hit_delay | hit_ramp | hit_tapctl | hit_pos | hit_status;
    wire logic wr_delay = wr_en & hit_delay;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // ------------------------------------------------------------------
    // delay, ramp and tap control registers
    // ------------------------------------------------------------------
    logic inv_q;
    adsw_code_t fine_q, target_q, coarse_q;
    logic ramp_en_q, ramp_rate_q;
    logic [`ADSW_SEL_W-1:0] sel_q;
    logic zoom_q;
    wire adsw_code_t wr_coarse = pwdata[`ADSW_COARSE_LSB +: 8];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_q <= 1'b0;
            fine_q <= `ADSW_DELAY_RST;
            target_q <= `ADSW_DELAY_RST;
        end else if (wr_delay) begin
            inv_q <= pwdata[`ADSW_INV_BIT];
            fine_q <= pwdata[`ADSW_FINE_LSB +: 8];
            target_q <= wr_coarse;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_en_q <= 1'b0;
            ramp_rate_q <= 1'b0;
        end else if (wr_en & hit_ramp) begin
            ramp_en_q <= pwdata[`ADSW_RAMP_EN_BIT];
            ramp_rate_q <= pwdata[`ADSW_RAMP_RATE_BIT];
        end
    end

    // select field is four bits wide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 4'h0;
            zoom_q <= `ADSW_ZOOM_RST;
        end else if (wr_en & hit_tapctl) begin
            sel_q <= pwdata[`ADSW_SEL_LSB +: `ADSW_SEL_W];
            zoom_q <= pwdata[`ADSW_ZOOM_BIT];
        end
    end

    // ------------------------------------------------------------------
    // coarse ramp
    // ------------------------------------------------------------------
    adsw_ramp_state_t state_q, state_d;
    logic [7:0] tick_q;
    adsw_code_t coarse_d;
    wire logic tick_wrap = (tick_q == 8'(`ADSW_RAMP_PERIOD - 1));
    wire logic fast_pulse = (tick_q[5:0] == 6'h3F);
    // slow one step, fast four steps per period
    wire logic step_now = ramp_rate_q ? fast_pulse : tick_wrap;
    wire logic going_up = (target_q > coarse_q);
    wire logic at_target = (target_q == coarse_q);

    always_comb begin
        state_d = state_q;
        coarse_d = coarse_q;
        if (wr_delay) begin
            if (!ramp_en_q) begin
                coarse_d = wr_coarse;
                state_d = ADSW_IDLE;
            end else begin
                state_d = ADSW_RAMP;
            end
        end else begin
            unique case (state_q)
                ADSW_IDLE: begin
                    state_d = ADSW_IDLE;
                end
                ADSW_RAMP: begin
                    // step toward target, stop when equal
                    if (at_target) begin
                        state_d = ADSW_IDLE;
                    end else if (step_now) begin
                        coarse_d = going_up ? coarse_q + 8'h01 : coarse_q - 8'h01;
                    end
                end
                default: begin
                    state_d = ADSW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ADSW_IDLE;
            coarse_q <= `ADSW_DELAY_RST;
            tick_q <= 8'h00;
        end else begin
            state_q <= state_d;
            coarse_q <= coarse_d;
            // tick runs on across a restart, so a new ramp keeps the old step
            // phase; its first step may come before a full period
            tick_q <= (state_d == ADSW_RAMP && state_q == ADSW_RAMP) ? tick_q + 8'h01 : 8'h00;
        end
    end

    // applied codes drive the clock path live
    assign clock_invert_delay = inv_q;
    assign coarse_delay_code = coarse_q;
    assign fine_delay_code = fine_q;
    assign sample_tap_select = sel_q;
    assign tap_step_zoom = zoom_q;
    // both edges in single channel mode
    assign dual_edge_sample = single_channel_mode;

    // ------------------------------------------------------------------
    // reference edge detector and position flags
    // ------------------------------------------------------------------
    logic [2:0] sr_sync_q;
    logic sr_level_q;
    logic [1:0] edge_cnt_q;
    logic [`ADSW_TAPS-1:0] tap_s1_q, tap_s2_q, tap_s3_q;
    logic [`ADSW_TAPS-1:0] pos_q;
    wire logic sr_agree = (sr_sync_q[1] == sr_sync_q[2]);
    wire logic sr_rise = sr_agree & sr_sync_q[2] & ~sr_level_q;
    wire logic pos_valid = (edge_cnt_q == 2'(`ADSW_MIN_EDGES));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_sync_q <= 3'h0;
            sr_level_q <= 1'b0;
            tap_s1_q <= 24'h000000;
            tap_s2_q <= 24'h000000;
            tap_s3_q <= 24'h000000;
        end else begin
            sr_sync_q <= {sr_sync_q[1:0], sysref_pin};
            sr_level_q <= sr_agree ? sr_sync_q[2] : sr_level_q;
            tap_s1_q <= tap_sample_pin;
            tap_s2_q <= tap_s1_q;
            tap_s3_q <= tap_s2_q;
        end
    end

    // count edges; latch flags on each edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_q <= 2'h0;
            pos_q <= 24'hFFFFFF;
        end else if (sr_rise) begin
            edge_cnt_q <= pos_valid ? edge_cnt_q : edge_cnt_q + 2'h1;
            pos_q <= tap_s3_q | {1'b1, 22'h000000, 1'b1};
        end
    end

    // capture pulse one clock after each detected reference rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysref_captured <= 1'b0;
        end else begin
            sysref_captured <= sr_rise;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire logic [31:0] rd_delay = {15'h0000, inv_q, target_q, fine_q};
    wire logic [31:0] rd_ramp = {30'h00000000, ramp_rate_q, ramp_en_q};
    wire logic [31:0] rd_tap = {27'h0000000, zoom_q, sel_q};
    wire logic [31:0] rd_pos = {8'h00, pos_q};
    wire logic [31:0] rd_stat = {22'h000000, coarse_q, pos_valid, state_q == ADSW_RAMP};
    assign prdata = hit_delay ? rd_delay :
                    hit_ramp ? rd_ramp :
                    hit_tapctl ? rd_tap :
                    hit_pos ? rd_pos :
                    hit_status ? rd_stat : 32'h00000000;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // spacing checks skip write cycles: a write restarts the ramp and may
    // land between two steps
    sequence s_ramp_request;
        wr_delay && ramp_en_q;
    endsequence
    sequence s_ramp_running;
        state_q == ADSW_RAMP ##0 target_q == $past(wr_coarse);
    endsequence

    a_direct_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_delay && !ramp_en_q) |=> coarse_q == $past(wr_coarse))
        else $error("direct coarse write not applied");
    a_ramp_step_size: assert property (@(posedge pclk) disable iff (!presetn)
        (coarse_q != $past(coarse_q) && !$past(wr_delay)) |->
        (coarse_q == $past(coarse_q) + 8'h01 || coarse_q == $past(coarse_q) - 8'h01))
        else $error("ramp jumped more than one step");
    a_slow_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ADSW_RAMP && !ramp_rate_q && !wr_delay && tick_q != 8'hFF)
        |=> coarse_q == $past(coarse_q))
        else $error("slow ramp stepped off its period");
    a_edge_flags: assert property (@(posedge pclk) disable iff (!presetn)
        pos_q[0] && pos_q[`ADSW_TAPS-1])
        else $error("edge tap flags not set");
    a_valid_count: assert property (@(posedge pclk) disable iff (!presetn)
        pos_valid |-> $past(edge_cnt_q) >= 2'h2)
        else $error("flags valid too early");
    a_ramp_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ADSW_RAMP && at_target && !wr_delay) |=> state_q == ADSW_IDLE)
        else $error("ramp did not stop");
    a_ramp_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_ramp_request |=> s_ramp_running)
        else $error("ramp not started");
    a_fine_indep: assert property (@(posedge pclk) disable iff (!presetn)
        wr_delay |=> fine_q == $past(pwdata[7:0]) && clock_invert_delay == $past(pwdata[16]))
        else $error("fine or invert not applied");
    a_fast_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ADSW_RAMP && ramp_rate_q && !wr_delay && tick_q[5:0] != 6'h3F)
        |=> coarse_q == $past(coarse_q))
        else $error("fast ramp stepped off its period");
    a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ADSW_IDLE && !wr_delay)
        |=> coarse_q == $past(coarse_q))
        else $error("coarse moved while idle");
    a_flag_latch: assert property (@(posedge pclk) disable iff (!presetn)
        sr_rise
        |=> pos_q[22:1] == $past(tap_s3_q[22:1]))
        else $error("position flags not latched");
    a_valid_hold: assert property (@(posedge pclk) disable iff (!presetn)
        pos_valid
        |=> pos_valid)
        else $error("flags valid dropped");
    a_capture_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        sr_rise
        |=> sysref_captured ##1 !sysref_captured)
        else $error("reference capture pulse wrong");
endmodule
`default_nettype wire

/* verif/adsw_src.sv */
/*
 * clock source stand-in: periodic reference pulse and per-tap capture levels.
 * assumes pclk is the device clock; the bench sets run and pattern.
 */
`default_nettype none
module adsw_src (
    // from the bench
    input wire logic pclk,
    input wire logic run,
    input wire logic [23:0] pattern,
    // to the block
    output logic sysref_pin,
    output logic [23:0] tap_sample_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase_q = 4'h0;
    initial sysref_pin = 1'b0;
    initial tap_sample_pin = 24'h000000;
    // setup, periodic rises
    // taps follow the pattern one clock later; the reference rises every 16 clocks, low when not running
    always @(posedge pclk) begin
        tap_sample_pin <= pattern;
        phase_q <= run ? phase_q + 4'h1 : 4'h0;
        sysref_pin <= run & phase_q[3];
    end
endmodule
`default_nettype wire

/* verif/tb.sv */
/*
 * self-checking bench: apb register tests, ramp timing, capture window.
 * assumes adsw_regs.svh on the include path and a zero-wait apb slave.
 */
`include "adsw_regs.svh"
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic single_channel_mode = 1'b0;
    logic run = 1'b0;
    logic [23:0] pattern = 24'h0F0F00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, sysref_pin, clock_invert_delay;
    logic tap_step_zoom, dual_edge_sample, sysref_captured;
    logic [23:0] tap_sample_pin;
    logic [`ADSW_SEL_W-1:0] sample_tap_select;
    adsw_pkg::adsw_code_t coarse_delay_code, fine_delay_code;
    int err_total = 0;
    int num_checks = 0;
    int caps = 0;

    always #25 pclk = ~pclk;
    always @(posedge pclk) if (sysref_captured === 1'b1) caps <= caps + 1;

    adsw_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .single_channel_mode(single_channel_mode),
        .sysref_pin(sysref_pin), .tap_sample_pin(tap_sample_pin),
        .clock_invert_delay(clock_invert_delay), .coarse_delay_code(coarse_delay_code),
        .fine_delay_code(fine_delay_code), .sample_tap_select(sample_tap_select),
        .tap_step_zoom(tap_step_zoom), .dual_edge_sample(dual_edge_sample),
        .sysref_captured(sysref_captured));
    adsw_src src (.pclk(pclk), .run(run), .pattern(pattern), .sysref_pin(sysref_pin),
        .tap_sample_pin(tap_sample_pin));

    // invert set, fine 0x5A, coarse from the caller
    function automatic logic [31:0] dly(input logic [7:0] c);
        return {15'h0000, 1'h1, c, 8'h5A};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
    endtask

    // applied coarse and ramping flag from the status word
    task automatic stat(input logic [7:0] c, input logic r);
        apb(1'b0, `ADSW_OFF_STATUS, 32'h00000000);
        `CHK({rd[9:2], rd[0]}, {c, r})
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic wait_caps(input int k);
        int n = 0;
        while (caps < k && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (caps < k) begin
            err_total++;
            report_and_stop();
        end
        #1;
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`ADSW_OFF_DELAY, 32'h00000000);
        rchk(`ADSW_OFF_RAMP, 32'h00000000);
        rchk(`ADSW_OFF_TAPCTL, 32'h00000010);
        rchk(`ADSW_OFF_POS, 32'h00FFFFFF);
        `CHK(dual_edge_sample, 1'h0)
        apb(1'b1, `ADSW_OFF_DELAY, dly(8'hC3));
        step(1);
        `CHK({clock_invert_delay, coarse_delay_code, fine_delay_code}, 17'h1C35A)
        rchk(`ADSW_OFF_DELAY, dly(8'hC3));
        // unmapped place: refused, reads zero
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        `CHK(err, 1'h1)
        rchk(12'h020, 32'h00000000);
        `CHK(err, 1'h1)
        apb(1'b1, `ADSW_OFF_RAMP, 32'h00000001);
        apb(1'b1, `ADSW_OFF_DELAY, dly(8'hC5));
        step(200);
        `CHK(coarse_delay_code, 8'hC3)
        stat(8'hC3, 1'h1);
        step(100);
        `CHK(coarse_delay_code, 8'hC4)
        step(260);
        stat(8'hC5, 1'h0);
        apb(1'b1, `ADSW_OFF_RAMP, 32'h00000003);
        apb(1'b1, `ADSW_OFF_DELAY, dly(8'hC9));
        step(40);
        `CHK(coarse_delay_code, 8'hC5)
        step(60);
        `CHK(coarse_delay_code, 8'hC6)
        apb(1'b1, `ADSW_OFF_DELAY, dly(8'hC3));
        step(1);
        `CHK(coarse_delay_code, 8'hC6)
        step(230);
        stat(8'hC3, 1'h0);
        apb(1'b1, `ADSW_OFF_TAPCTL, 32'h0000003F);
        step(1);
        `CHK({sample_tap_select, tap_step_zoom}, 5'h1F)
        apb(1'b1, `ADSW_OFF_TAPCTL, 32'h00000007);
        step(1);
        `CHK({sample_tap_select, tap_step_zoom}, 5'h0E)
        @(posedge pclk);
        single_channel_mode <= 1'b1;
        run <= 1'b1;
        #1;
        `CHK(dual_edge_sample, 1'h1)
        wait_caps(2);
        apb(1'b0, `ADSW_OFF_STATUS, 32'h00000000);
        `CHK(rd[1], 1'h0)
        wait_caps(3);
        step(2);
        `CHK(caps, 3)
        apb(1'b0, `ADSW_OFF_STATUS, 32'h00000000);
        `CHK(rd[1], 1'h1)
        rchk(`ADSW_OFF_POS, 32'h008F0F01);
        // middle of the clear run 1..7, zoom set back to 1
        apb(1'b1, `ADSW_OFF_TAPCTL, 32'h00000014);
        step(1);
        `CHK({sample_tap_select, tap_step_zoom}, 5'h09)
        // select back to zero, as calibration would need
        apb(1'b1, `ADSW_OFF_TAPCTL, 32'h00000010);
        step(1);
        `CHK({sample_tap_select, tap_step_zoom}, 5'h01)
        report_and_stop();
    end

    initial begin
        #(20000 * 50);
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
